// *** inc/fpi_pkg.sv ***
// Purpose: shared constants and types for the front panel indicator block
// Assumes: 50 MHz system clock
// Notes: register offsets are word aligned byte addresses
package fpi_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned ID_FLASH_S = 15;
    localparam int unsigned ID_FLASH_CYC = ID_FLASH_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ) / 1000;
    localparam int unsigned SLOW_BLINK_MS = 1000;
    localparam int unsigned SLOW_BLINK_CYC = (SLOW_BLINK_MS * CLK_HZ) / 1000;
    localparam int unsigned FAST_BLINK_MS = 50;
    localparam int unsigned FAST_BLINK_CYC = (FAST_BLINK_MS * CLK_HZ) / 1000;
    localparam int unsigned ACT_BLINK_MS = 60;
    localparam int unsigned ACT_BLINK_CYC = (ACT_BLINK_MS * CLK_HZ) / 1000;
    localparam int unsigned NUM_BTN = 4;
    localparam int unsigned BTN_ID = 0;
    localparam int unsigned BTN_NMI = 1;
    localparam int unsigned BTN_RST = 2;
    localparam int unsigned BTN_PWR = 3;
    localparam int unsigned NUM_PORT = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_HEALTH = 4'h8;
    localparam int unsigned CTRL_ID_SOFT = 0;
    localparam int unsigned CTRL_SLEEP_EN = 1;
    localparam int unsigned CTRL_ACPI_EN = 2;
    localparam int unsigned CTRL_NMI_CLR = 3;
    localparam logic [7:0] ACT_LIMIT = 8'hff;
    typedef enum logic [2:0] {
        FPI_HEALTH_OFF = 3'h0,
        FPI_HEALTH_OK = 3'h1,
        FPI_HEALTH_DEGRADED = 3'h2,
        FPI_HEALTH_CRITICAL = 3'h3,
        FPI_HEALTH_NONCRIT = 3'h4
    } fpi_health_e;
    typedef enum logic [2:0] {
        FPI_PWR_OFF = 3'h0,
        FPI_PWR_ON = 3'h1,
        FPI_PWR_S0 = 3'h2,
        FPI_PWR_S1S3 = 3'h3,
        FPI_PWR_S4S5 = 3'h4
    } fpi_pwr_e;
    typedef struct packed {
        logic green;
        logic amber;
    } fpi_bicolor_s;
endpackage

// *** hdl/fpi_top.sv ***
// Purpose: front panel buttons and indicators of a pedestal server
// Assumes: all inputs synchronous to clk_i; activity strobes are one cycle each
// Notes: registers are reached over a plain strobe port, read data one cycle later
// What this block does
// - each identify press toggles identify light; front and board lights match
// - remote identify request flashes identify light for fifteen seconds, then dark
// - nmi press halts server and raises nmi toward processor
// - one activity light per network port, up to four ports
// - port light steady while link detected, dark when idle without link
// - linked port light flashes at rate following that port's traffic
// - reset press reboots and reinitialises whole system
// - status light driven identically front and rear, state from management
// - steady green ready no alarm; flashing green when degraded
// - steady amber on critical alarm
// - flashing amber on non-critical failure
// - status dark without mains power or in clean standby
// - power press passed as pulse to platform management controller
// - with acpi sleep enabled, power button acts as sleep button
// - power light slow blink in sleep states one to three
// - power light steady in s0 or power on without acpi
// - power light dark when off or in s4 and s5
// - drive light flashes on disk accesses, dark without access
// - identify steady after button, flashing when software selects, else dark
// - intrusion switch state readable by management software
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module fpi_top #(
    parameter int unsigned ID_FLASH_CYCLES = fpi_pkg::ID_FLASH_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = fpi_pkg::DEBOUNCE_CYC,
    parameter int unsigned SLOW_BLINK_CYCLES = fpi_pkg::SLOW_BLINK_CYC,
    parameter int unsigned FAST_BLINK_CYCLES = fpi_pkg::FAST_BLINK_CYC,
    parameter int unsigned ACT_BLINK_CYCLES = fpi_pkg::ACT_BLINK_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // operator buttons, active low, and intrusion switch
    input wire logic [fpi_pkg::NUM_BTN-1:0] btn_n_i,
    input wire logic intrusion_i,
    // remote identify request pulse
    input wire logic chassis_identify_i,
    // sleep state from chipset
    input wire logic [2:0] pwr_state_i,
    // health state from platform management
    input wire logic [2:0] health_i,
    // network ports and disk activity
    input wire logic [fpi_pkg::NUM_PORT-1:0] port_link_i,
    input wire logic [fpi_pkg::NUM_PORT-1:0] port_act_i,
    input wire logic disk_act_i,
    // events toward platform
    output logic nmi_o,
    output logic sys_reset_o,
    output logic pwr_btn_o,
    output logic sleep_btn_o,
    // indicators
    output logic id_led_front_o,
    output logic id_led_board_o,
    output logic pwr_led_o,
    output fpi_pkg::fpi_bicolor_s status_front_o,
    output fpi_pkg::fpi_bicolor_s status_rear_o,
    output logic disk_led_o,
    output logic [fpi_pkg::NUM_PORT-1:0] port_led_o
);
    localparam int unsigned NB = fpi_pkg::NUM_BTN;
    localparam int unsigned NP = fpi_pkg::NUM_PORT;

    typedef struct packed {
        // two-flop synchroniser and debounce per button
        logic [NB-1:0] sync1;
        logic [NB-1:0] sync2;
        logic [NB-1:0] stable;
        logic [NB-1:0][23:0] deb_cnt;
        // identify and control bits
        logic id_btn_on;
        logic id_soft;
        logic sleep_en;
        logic acpi_en;
        logic [31:0] id_flash_cnt;
        // event pulses and the sticky nmi level
        logic nmi;
        logic sys_reset;
        logic pwr_btn;
        logic sleep_btn;
        // blink timebases shared by all lights but the port lights
        logic [25:0] slow_cnt;
        logic slow_ph;
        logic [25:0] fast_cnt;
        logic fast_ph;
        // per-port traffic level, divider and blink phase
        logic [NP-1:0][7:0] act_level;
        logic [NP-1:0][25:0] act_cnt;
        logic [NP-1:0] act_ph;
        logic [25:0] disk_cnt;
        // registered lights and read data
        logic id_led;
        logic pwr_led;
        fpi_pkg::fpi_bicolor_s status;
        logic disk_led;
        logic [NP-1:0] port_led;
        logic [31:0] rdata;
    } fpi_state_s;

    fpi_state_s state_reg;
    fpi_state_s state_next;

    // one step of a free running blink divider; returns true at wrap
    // a limit that shrinks below the count still wraps at once
    function automatic logic wrap_at(input logic [25:0] cnt, input int unsigned lim);
        wrap_at = (cnt >= 26'(lim - 1));
    endfunction

    // next state of the whole block
    always_comb
    begin
        logic [NB-1:0] press;
        logic id_flash;
        logic [7:0] lvl;
        int unsigned per;
        press = '0;
        id_flash = 1'b0;
        lvl = '0;
        per = 0;
        state_next = state_reg;

        // debounce: a level must hold for the debounce time before it counts
        // a release is debounced too, so one press gives one event
        state_next.sync1 = ~btn_n_i;
        state_next.sync2 = state_reg.sync1;
        for (int b = 0; b < NB; b++)
        begin
            if (state_reg.sync2[b] == state_reg.stable[b])
            begin
                state_next.deb_cnt[b] = '0;
            end
            else if (state_reg.deb_cnt[b] >= 24'(DEBOUNCE_CYCLES - 1))
            begin
                state_next.deb_cnt[b] = '0;
                state_next.stable[b] = state_reg.sync2[b];
                press[b] = state_reg.sync2[b];
            end
            else
            begin
                state_next.deb_cnt[b] = state_reg.deb_cnt[b] + 24'h1;
            end
        end

        // identify: button toggles, remote request flashes for a fixed time
        if (press[fpi_pkg::BTN_ID])
        begin
            state_next.id_btn_on = ~state_reg.id_btn_on;
        end
        // a repeated request restarts the full flash span
        if (chassis_identify_i)
        begin
            state_next.id_flash_cnt = 32'(ID_FLASH_CYCLES);
        end
        else if (state_reg.id_flash_cnt != '0)
        begin
            state_next.id_flash_cnt = state_reg.id_flash_cnt - 32'h1;
        end

        // button events to the platform, one cycle pulses
        // nmi stays raised until software clears it
        state_next.nmi = state_reg.nmi | press[fpi_pkg::BTN_NMI];
        state_next.sys_reset = press[fpi_pkg::BTN_RST];
        state_next.pwr_btn = press[fpi_pkg::BTN_PWR] & ~state_reg.sleep_en;
        state_next.sleep_btn = press[fpi_pkg::BTN_PWR] & state_reg.sleep_en;

        // register writes
        // writes to unmapped offsets change nothing
        if (wr_i && addr_i == fpi_pkg::REG_CTRL)
        begin
            state_next.id_soft = wdata_i[fpi_pkg::CTRL_ID_SOFT];
            state_next.sleep_en = wdata_i[fpi_pkg::CTRL_SLEEP_EN];
            state_next.acpi_en = wdata_i[fpi_pkg::CTRL_ACPI_EN];
            // a new press in the same cycle keeps nmi raised
            if (wdata_i[fpi_pkg::CTRL_NMI_CLR] && !press[fpi_pkg::BTN_NMI])
            begin
                state_next.nmi = 1'b0;
            end
        end

        // shared blink timebases
        if (wrap_at(state_reg.slow_cnt, SLOW_BLINK_CYCLES))
        begin
            state_next.slow_cnt = '0;
            state_next.slow_ph = ~state_reg.slow_ph;
        end
        else
        begin
            state_next.slow_cnt = state_reg.slow_cnt + 26'h1;
        end
        if (wrap_at(state_reg.fast_cnt, FAST_BLINK_CYCLES))
        begin
            state_next.fast_cnt = '0;
            state_next.fast_ph = ~state_reg.fast_ph;
        end
        else
        begin
            state_next.fast_cnt = state_reg.fast_cnt + 26'h1;
        end

        // network ports: traffic level speeds the blink, decays each half period
        // halving at each wrap lets the blink slow down once traffic stops
        for (int p = 0; p < NP; p++)
        begin
            lvl = state_reg.act_level[p];
            if (port_act_i[p] && lvl != fpi_pkg::ACT_LIMIT)
            begin
                lvl = lvl + 8'h1;
            end
            per = ACT_BLINK_CYCLES / (1 + int'(state_reg.act_level[p]));
            // a heavy traffic level must never stall the divider
            if (per == 0)
            begin
                per = 1;
            end
            if (wrap_at(state_reg.act_cnt[p], per))
            begin
                state_next.act_cnt[p] = '0;
                state_next.act_ph[p] = ~state_reg.act_ph[p];
                lvl = lvl >> 1;
            end
            else
            begin
                state_next.act_cnt[p] = state_reg.act_cnt[p] + 26'h1;
            end
            state_next.act_level[p] = lvl;
            // no link always wins; link alone lights the port steadily
            if (!port_link_i[p])
            begin
                state_next.port_led[p] = 1'b0;
            end
            else if (state_reg.act_level[p] != '0)
            begin
                state_next.port_led[p] = state_reg.act_ph[p];
            end
            else
            begin
                state_next.port_led[p] = 1'b1;
            end
        end

        // drive light: each access stretches to one blink period
        // a lone access still gives at least one visible blink
        if (disk_act_i)
        begin
            state_next.disk_cnt = 26'(ACT_BLINK_CYCLES);
        end
        else if (state_reg.disk_cnt != '0)
        begin
            state_next.disk_cnt = state_reg.disk_cnt - 26'h1;
        end
        state_next.disk_led = (state_reg.disk_cnt != '0) & state_reg.fast_ph;

        // identify light: software or remote request flashes, button steady
        id_flash = state_reg.id_soft | (state_reg.id_flash_cnt != '0);
        if (id_flash)
        begin
            state_next.id_led = state_reg.fast_ph;
        end
        else
        begin
            state_next.id_led = state_reg.id_btn_on;
        end

        // power light from sleep state
        // unused and deep sleep codes fall to the default, dark
        case (fpi_pkg::fpi_pwr_e'(pwr_state_i))
            fpi_pkg::FPI_PWR_ON:
            begin
                state_next.pwr_led = 1'b1;
            end
            fpi_pkg::FPI_PWR_S0:
            begin
                state_next.pwr_led = state_reg.acpi_en | 1'b1;
            end
            fpi_pkg::FPI_PWR_S1S3:
            begin
                state_next.pwr_led = state_reg.slow_ph;
            end
            default:
            begin
                state_next.pwr_led = 1'b0;
            end
        endcase

        // status light from health state
        // unknown health codes read as dark
        case (fpi_pkg::fpi_health_e'(health_i))
            fpi_pkg::FPI_HEALTH_OK:
            begin
                state_next.status = '{green: 1'b1, amber: 1'b0};
            end
            fpi_pkg::FPI_HEALTH_DEGRADED:
            begin
                state_next.status = '{green: state_reg.slow_ph, amber: 1'b0};
            end
            fpi_pkg::FPI_HEALTH_CRITICAL:
            begin
                state_next.status = '{green: 1'b0, amber: 1'b1};
            end
            fpi_pkg::FPI_HEALTH_NONCRIT:
            begin
                state_next.status = '{green: 1'b0, amber: state_reg.slow_ph};
            end
            default:
            begin
                state_next.status = '{green: 1'b0, amber: 1'b0};
            end
        endcase

        // register reads, data in the next cycle only
        // unmapped offsets read as zero
        state_next.rdata = '0;
        if (rd_i)
        begin
            case (addr_i)
                fpi_pkg::REG_CTRL:
                begin
                    state_next.rdata = 32'({state_reg.nmi, state_reg.acpi_en, state_reg.sleep_en,
                        state_reg.id_soft});
                end
                fpi_pkg::REG_STATUS:
                begin
                    state_next.rdata = 32'({state_reg.id_btn_on, state_reg.stable, intrusion_i});
                end
                fpi_pkg::REG_HEALTH:
                begin
                    state_next.rdata = 32'({pwr_state_i, health_i});
                end
                default:
                begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    // single state register
    // all-zero reset matches the idle level of every pin, so no false press
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops
    // paired lights share one flop so they cannot drift apart
    assign rdata_o = state_reg.rdata;
    assign nmi_o = state_reg.nmi;
    assign sys_reset_o = state_reg.sys_reset;
    assign pwr_btn_o = state_reg.pwr_btn;
    assign sleep_btn_o = state_reg.sleep_btn;
    assign id_led_front_o = state_reg.id_led;
    assign id_led_board_o = state_reg.id_led;
    assign pwr_led_o = state_reg.pwr_led;
    assign status_front_o = state_reg.status;
    assign status_rear_o = state_reg.status;
    assign disk_led_o = state_reg.disk_led;
    assign port_led_o = state_reg.port_led;
endmodule

// *** sim/fpi_checker.sv ***
// Purpose: port-level assertions for the front panel indicator block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached to fpi_top by the bind at the foot of this file
`timescale 1ns/100ps
module fpi_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port and levels
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [2:0] pwr_state_i,
    input wire logic [2:0] health_i,
    input wire logic [fpi_pkg::NUM_PORT-1:0] port_link_i,
    // outputs watched
    input wire logic [fpi_pkg::NUM_PORT-1:0] port_led_o,
    input wire logic sys_reset_o,
    input wire logic pwr_btn_o,
    input wire logic sleep_btn_o,
    input wire logic id_led_front_o,
    input wire logic id_led_board_o,
    input wire logic pwr_led_o,
    input wire fpi_pkg::fpi_bicolor_s status_front_o,
    input wire fpi_pkg::fpi_bicolor_s status_rear_o
);
    // every check samples on the rising edge and rests during reset
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_id_lights_same: assert property (id_led_front_o == id_led_board_o)
        else $error("identify lights differ");
    a_status_same: assert property (status_front_o == status_rear_o)
        else $error("front and rear status differ");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data without read strobe");
    a_rst_one_pulse: assert property (sys_reset_o |=> !sys_reset_o)
        else $error("system reset pulse too long");
    a_pwr_sleep_excl: assert property (!(pwr_btn_o && sleep_btn_o))
        else $error("power and sleep events together");
    a_pwr_led_dark: assert property ((pwr_state_i == 3'h0 || pwr_state_i >= 3'h4)[*4] |-> !pwr_led_o)
        else $error("power light lit while off");
    a_pwr_led_lit: assert property ((pwr_state_i == 3'h1 || pwr_state_i == 3'h2)[*4] |-> pwr_led_o)
        else $error("power light dark while on");
    a_status_ok: assert property ((health_i == 3'h1)[*4] |-> status_front_o == 2'b10)
        else $error("status not steady green");
    a_status_crit: assert property ((health_i == 3'h3)[*4] |-> status_front_o == 2'b01)
        else $error("status not steady amber");
    a_status_dark: assert property ((health_i == 3'h0)[*4] |-> status_front_o == 2'b00)
        else $error("status lit in standby");
    a_link_dark: assert property ((port_link_i == 4'h0)[*4] |-> port_led_o == 4'h0)
        else $error("port light lit without link");
endmodule
bind fpi_top fpi_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pwr_state_i(pwr_state_i), .health_i(health_i), .port_link_i(port_link_i), .port_led_o(port_led_o),
    .sys_reset_o(sys_reset_o), .pwr_btn_o(pwr_btn_o), .sleep_btn_o(sleep_btn_o),
    .id_led_front_o(id_led_front_o), .id_led_board_o(id_led_board_o), .pwr_led_o(pwr_led_o),
    .status_front_o(status_front_o), .status_rear_o(status_rear_o));

// *** sim/fpi_partner.sv ***
// Purpose: behavioural management controller and traffic sources
// Assumes: bench asks for identify and traffic by level inputs
// Notes: counts the event pulses that the panel block sends
`timescale 1ns/100ps
module fpi_partner (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // scenario controls
    input wire logic ident_go_i,
    input wire logic [4:0] traffic_i,
    // events from the panel
    input wire logic pwr_btn_i,
    input wire logic sleep_btn_i,
    input wire logic sys_reset_i,
    // requests and activity toward the panel
    output logic chassis_identify_o,
    output logic [3:0] port_act_o,
    output logic disk_act_o,
    // event tallies
    output logic [7:0] n_pwr_o,
    output logic [7:0] n_sleep_o,
    output logic [7:0] n_rst_o
);
    logic go_d;
    logic [1:0] div;
    // one identify pulse per request, activity every fourth cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            {go_d, div, chassis_identify_o, port_act_o, disk_act_o} <= '0;
            {n_pwr_o, n_sleep_o, n_rst_o} <= '0;
        end
        else
        begin
            go_d <= ident_go_i;
            chassis_identify_o <= ident_go_i && !go_d;
            div <= div + 2'h1;
            {disk_act_o, port_act_o} <= (div == 2'h0) ? traffic_i : 5'h0;
            n_pwr_o <= n_pwr_o + {7'h0, pwr_btn_i};
            n_sleep_o <= n_sleep_o + {7'h0, sleep_btn_i};
            n_rst_o <= n_rst_o + {7'h0, sys_reset_i};
        end
    end
endmodule

// *** sim/fpi_top_tb.sv ***
// Purpose: self-checking bench for the front panel indicator block
// Assumes: shortened debounce, blink and flash counts
// Notes: steady light states run from a table, blinking cases by hand
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module fpi_top_tb;
    typedef struct packed {logic [2:0] pw; logic [2:0] hl; logic led; logic [1:0] st;} fpi_row_s;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, intrusion = 1'b0, ident_go = 1'b0;
    logic [3:0] addr = 4'h0, btn_n = 4'hf, link = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [2:0] pwr = 3'h0, health = 3'h0;
    logic [4:0] traffic = 5'h0;
    logic [3:0] port_act, port_led;
    logic [7:0] n_pwr, n_sleep, n_rst;
    logic ci, disk_act, nmi, sys_rst, pwr_btn, sleep_btn, id_f, id_b, pwr_led, disk_led;
    fpi_pkg::fpi_bicolor_s st_f, st_r;
    int err_total = 0, n_compared = 0, k;
    wire logic [5:0] leds = {pwr_led, st_f.green, st_f.amber, id_f, disk_led, port_led[0]};
    fpi_row_s rows[8] = '{'{3'h0, 3'h0, 1'b0, 2'b00}, '{3'h1, 3'h1, 1'b1, 2'b10}, '{3'h2, 3'h3, 1'b1, 2'b01},
        '{3'h4, 3'h0, 1'b0, 2'b00}, '{3'h5, 3'h5, 1'b0, 2'b00}, '{3'h2, 3'h1, 1'b1, 2'b10},
        '{3'h1, 3'h3, 1'b1, 2'b01}, '{3'h7, 3'h0, 1'b0, 2'b00}};
    fpi_top #(.ID_FLASH_CYCLES(200), .DEBOUNCE_CYCLES(4), .SLOW_BLINK_CYCLES(16), .FAST_BLINK_CYCLES(4),
        .ACT_BLINK_CYCLES(32)) dut (.clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .btn_n_i(btn_n), .intrusion_i(intrusion), .chassis_identify_i(ci),
        .pwr_state_i(pwr), .health_i(health), .port_link_i(link), .port_act_i(port_act), .disk_act_i(disk_act),
        .nmi_o(nmi), .sys_reset_o(sys_rst), .pwr_btn_o(pwr_btn), .sleep_btn_o(sleep_btn), .id_led_front_o(id_f),
        .id_led_board_o(id_b), .pwr_led_o(pwr_led), .status_front_o(st_f), .status_rear_o(st_r),
        .disk_led_o(disk_led), .port_led_o(port_led));
    fpi_partner p (.clk_i(clk), .nrst_i(nrst), .ident_go_i(ident_go), .traffic_i(traffic), .pwr_btn_i(pwr_btn),
        .sleep_btn_i(sleep_btn), .sys_reset_i(sys_rst), .chassis_identify_o(ci), .port_act_o(port_act),
        .disk_act_o(disk_act), .n_pwr_o(n_pwr), .n_sleep_o(n_sleep), .n_rst_o(n_rst));
    // 50 MHz clock
    always #10 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // hold a button past the debounce span, then release it
    task automatic press(input int b);
        @(posedge clk);
        btn_n[b] <= 1'b0;
        tick(12);
        btn_n[b] <= 1'b1;
        tick(12);
    endtask
    // count the cycles in which one light is lit
    task automatic highs(input int b, input int n);
        k = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1 if (leds[b] === 1'b1) k++;
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog far beyond the eleven hundred or so cycles the tests take
    initial
    begin
        #400000;
        err_total++;
        conclude();
    end
    initial
    begin
        tick(10);
        nrst <= 1'b1;
        @(posedge clk);
        #1 `CHK({rdata, nmi, pwr_led, st_f, id_f}, 37'h0)
        foreach (rows[i])
        begin
            @(posedge clk);
            pwr <= rows[i].pw;
            health <= rows[i].hl;
            tick(5);
            #1 `CHK(pwr_led, rows[i].led)
            `CHK(st_f, rows[i].st)
            `CHK(st_r, rows[i].st)
        end
        @(posedge clk);
        pwr <= 3'h3;
        health <= 3'h2;
        highs(5, 64);
        `CHK(k > 0 && k < 64, 1'b1)
        highs(4, 64);
        `CHK(k > 0 && k < 64, 1'b1)
        @(posedge clk);
        health <= 3'h4;
        highs(3, 64);
        `CHK(k > 0 && k < 64, 1'b1)
        highs(4, 32);
        `CHK(k, 0)
        rd_reg(fpi_pkg::REG_HEALTH);
        `CHK(d, {26'h0, 3'h3, 3'h4})
        rd_reg(fpi_pkg::REG_STATUS);
        `CHK(d[0], 1'b0)
        @(posedge clk);
        intrusion <= 1'b1;
        tick(4);
        rd_reg(fpi_pkg::REG_STATUS);
        `CHK(d[0], 1'b1)
        wr_reg(4'hc, 32'hffffffff);
        rd_reg(4'hc);
        `CHK(d, 32'h0)
        rd_reg(fpi_pkg::REG_CTRL);
        `CHK(d, 32'h0)
        press(0);
        highs(2, 32);
        `CHK(k, 32)
        rd_reg(fpi_pkg::REG_STATUS);
        `CHK(d[5:0], 6'h21)
        press(0);
        highs(2, 32);
        `CHK(k, 0)
        wr_reg(fpi_pkg::REG_CTRL, 32'h1);
        highs(2, 64);
        `CHK(k > 0 && k < 64, 1'b1)
        wr_reg(fpi_pkg::REG_CTRL, 32'h0);
        ident_go <= 1'b1;
        tick(2);
        ident_go <= 1'b0;
        highs(2, 64);
        `CHK(k > 0 && k < 64, 1'b1)
        tick(150);
        highs(2, 32);
        `CHK(k, 0)
        press(1);
        #1 `CHK(nmi, 1'b1)
        rd_reg(fpi_pkg::REG_CTRL);
        `CHK(d[3], 1'b1)
        wr_reg(fpi_pkg::REG_CTRL, 32'h8);
        tick(2);
        #1 `CHK(nmi, 1'b0)
        press(2);
        `CHK(n_rst, 8'h1)
        press(3);
        `CHK({n_pwr, n_sleep}, 16'h0100)
        wr_reg(fpi_pkg::REG_CTRL, 32'h6);
        rd_reg(fpi_pkg::REG_CTRL);
        `CHK(d, 32'h6)
        press(3);
        `CHK({n_pwr, n_sleep}, 16'h0101)
        link <= 4'h1;
        tick(4);
        highs(0, 32);
        `CHK(k, 32)
        @(posedge clk);
        traffic <= 5'h11;
        highs(0, 64);
        `CHK(k > 0 && k < 64, 1'b1)
        highs(1, 64);
        `CHK(k > 0 && k < 64, 1'b1)
        @(posedge clk);
        traffic <= 5'h0;
        link <= 4'hf;
        tick(80);
        #1 `CHK(port_led, 4'hf)
        highs(1, 16);
        `CHK(k, 0)
        @(posedge clk);
        link <= 4'h0;
        tick(4);
        #1 `CHK(port_led, 4'h0)
        // a reset in mid-run clears the sticky nmi and the control bits
        press(1);
        @(posedge clk);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        rd_reg(fpi_pkg::REG_CTRL);
        `CHK({d, nmi, n_rst}, 41'h0)
        conclude();
    end
endmodule
